// ### hdl/oa_pkg.sv
// constants and types for the output arbiter and threshold register bank
// assumes one 40 MHz system clock and 10-bit register offsets
package oa_pkg;
   localparam int NUM_CORES = 4;
   localparam int NUM_OUT = 12;
   localparam int NUM_HS = 5;
   localparam int NUM_START = 6;
   localparam int NUM_CUR = 4;
   localparam int THR_W = 3;
   localparam int LVL_W = 8;
   localparam int DEB_W = 12;
   localparam int OC_TRIM_W = 4;
   // register offsets
   localparam logic [9:0] OFF_HS_DRAIN = 10'h018a;
   localparam logic [9:0] OFF_HS_SRC = 10'h018b;
   localparam logic [9:0] OFF_LS_A = 10'h018c;
   localparam logic [9:0] OFF_LS_B = 10'h018d;
   localparam logic [9:0] OFF_LVL = 10'h019b;
   localparam logic [9:0] OFF_GRANTS = 10'h019c;
   localparam logic [9:0] OFF_DEB = 10'h019d;
   // field positions and values after reset
   localparam int DEB_POLICY_BIT = 12;
   localparam logic [12:0] DEB_RST = 13'h0001;
   localparam logic [14:0] THR_RST = 15'h0000;
   localparam logic [7:0] LVL_RST = 8'h00;
   localparam logic [3:0] GRANT_RST = 4'h0;
   // source threshold codes forced during bootstrap init
   localparam logic [2:0] SRC_THR_LO = 3'h1;
   localparam logic [2:0] SRC_THR_HI = 3'h2;
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int BS_WAIT_MS = 36;
   localparam int BS_WAIT_CYC = (CLK_HZ / 1000) * BS_WAIT_MS;
   localparam int OC_SETTLE_CYC = 4;
   typedef enum logic [1:0] {OC_IDLE, OC_WAIT, OC_STEP} oc_state_t;
endpackage

// ### hdl/boost_deb_if.sv
// link between the register bank and the boost comparator filter
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface boost_deb_if;
   logic sample;
   logic policy;
   logic [11:0] setting;
   logic filtered;
   modport ctrl (output sample, output policy, output setting, input filtered);
   modport filt (input sample, input policy, input setting, output filtered);
endinterface

// ### hdl/boost_debounce.sv
// digital filter for the synchronised boost comparator output
// assumes the sample is already synchronised to i_ref_clk
`timescale 1ns/1ps
module boost_debounce (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // filter link
   boost_deb_if.filt deb
);
   typedef struct packed {
      logic state;
      logic [11:0] cnt;
   } deb_st_t;
   deb_st_t st_r;
   deb_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (deb.sample != st_r.state)
      begin
         // >= so that lowering the setting mid-count still settles
         if (st_r.cnt >= deb.setting)
         begin
            st_nxt.state = deb.sample;
            st_nxt.cnt = '0;
         end
         else
         begin
            st_nxt.cnt = st_r.cnt + 12'h001;
         end
      end
      else if (deb.policy)
      begin
         if (st_r.cnt != '0)
         begin
            st_nxt.cnt = st_r.cnt - 12'h001;
         end
      end
      else
      begin
         st_nxt.cnt = '0;
      end
      if (i_rst)
      begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      st_r <= st_nxt;
   end

   assign deb.filtered = st_r.state;

   deb_reset_cnt_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!deb.policy && deb.sample == st_r.state) |=> st_r.cnt == '0)
      else $error("filter count not cleared");
   deb_decrement_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (deb.policy && deb.sample == st_r.state && st_r.cnt != '0)
      |=> st_r.cnt == $past(st_r.cnt) - 12'h001)
      else $error("filter count not decremented");
   deb_flip_time_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (deb.sample != st_r.state && st_r.cnt >= deb.setting)
      |=> st_r.state == $past(deb.sample) && st_r.cnt == '0)
      else $error("filtered state did not follow");
   deb_flip_c:
   cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(st_r.state));
endmodule

// ### hdl/output_arbiter_threshold_regs.sv
// output arbiter, diagnosis, offset trim and threshold registers
// assumes core commands, grants and bootstrap init flags come from
// logic on i_ref_clk; comparator and pin inputs are asynchronous
//
// Summary of operation
// - inputs and feedback broadcast to every core
// - four core command sets merged per output
// - diagnosis compares merged commands with feedback
// - core request starts offset trim routine
// - boost level writable by host and cores
// - eight-bit boost level sets boost threshold
// - per-core grant bit allows boost writes
// - boost trim applied automatically, no core action
// - policy zero: matching sample clears filter count
// - policy one: matching sample decrements filter count
// - filter time is clock times setting plus one
// - three-bit thresholds, five per register, one in LS_B
// - host writes every threshold register
// - core changes only thresholds of granted outputs
// - source threshold readback shows effective values
// - ungranted core filter writes are ignored
// - backdoor cannot write the boost level
// - init forces low source threshold, raised later
`timescale 1ns/1ps
module output_arbiter_threshold_regs #(
   parameter int BS_WAIT_CYC = oa_pkg::BS_WAIT_CYC
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // host register port
   input wire logic i_spi_wr,
   input wire logic i_spi_rd,
   input wire logic [9:0] i_spi_addr,
   input wire logic [15:0] i_spi_wdata,
   output logic [15:0] o_spi_rdata,
   // core backdoor port
   input wire logic i_bd_wr,
   input wire logic [1:0] i_bd_core,
   input wire logic [9:0] i_bd_addr,
   input wire logic [15:0] i_bd_wdata,
   input wire logic i_regs_locked,
   // core boost level writes
   input wire logic [3:0] i_core_lvl_wr,
   input wire logic [3:0][7:0] i_core_lvl_data,
   // core commands and grants
   input wire logic [3:0][11:0] i_core_cmd,
   input wire logic [3:0][11:0] i_output_grant_map,
   input wire logic [3:0] i_oc_req,
   // pins and analog feedback
   input wire logic [5:0] i_start_inputs,
   input wire logic [11:0] i_vds_fbk,
   input wire logic [3:0] i_cur_fbk,
   input wire logic i_uv_vccp,
   input wire logic i_amp_out,
   input wire logic i_boost_cmp,
   input wire logic [4:0] i_bs_init,
   input wire logic [4:0] i_boost_eol_trim,
   // to cores
   output logic [5:0] o_core_start,
   output logic [11:0] o_core_fbk,
   output logic [3:0] o_core_cur,
   // to analog
   output logic [11:0] o_drive_cmd,
   output logic [11:0] o_diag_mismatch,
   output logic [14:0] o_high_side_drain_limit,
   output logic [14:0] o_high_side_source_limit,
   output logic [17:0] o_low_side_drain_limit,
   output logic [7:0] o_boost_level,
   output logic o_boost_ok,
   output logic [3:0] o_oc_trim,
   output logic o_oc_busy
);
   localparam int TMR_W = $clog2(BS_WAIT_CYC + 1);

   typedef struct packed {
      logic [5:0] start_s1, start_s2;
      logic [11:0] fbk_s1, fbk_s2;
      logic [3:0] cur_s1, cur_s2;
      logic uv_s1, uv_s2, amp_s1, amp_s2, bcmp_s1, bcmp_s2;
      logic [11:0] drive, diag;
      logic [14:0] hs_drain, hs_src, ls_a, src_eff;
      logic [2:0] ls_b;
      logic [7:0] blevel, lvl_eff;
      logic [3:0] grants;
      logic [12:0] deb;
      logic [15:0] rdata;
      logic [TMR_W-1:0] tmr;
      logic bs_done;
      oa_pkg::oc_state_t oc_state;
      logic [3:0] oc_trim;
      logic [2:0] oc_cnt;
      logic oc_busy;
   } st_t;

   st_t st_r;
   st_t st_nxt;
   logic [11:0] merged;
   logic [11:0] bd_gr;
   logic signed [9:0] lvl_sum;
   boost_deb_if deb_if ();

   function automatic logic [14:0] fld_merge(input logic [14:0] old, input logic [14:0] wd,
                                             input logic [4:0] en);
      logic [14:0] r;
      r = old;
      for (int j = 0; j < oa_pkg::NUM_HS; j++)
      begin
         if (en[j])
         begin
            r[j*oa_pkg::THR_W +: oa_pkg::THR_W] = wd[j*oa_pkg::THR_W +: oa_pkg::THR_W];
         end
      end
      return r;
   endfunction

   // an output follows any granted core that drives it
   for (genvar o = 0; o < oa_pkg::NUM_OUT; o++)
   begin : g_merge
      logic [3:0] hits;
      for (genvar c = 0; c < oa_pkg::NUM_CORES; c++)
      begin : g_core
         assign hits[c] = i_core_cmd[c][o] & i_output_grant_map[c][o];
      end
      assign merged[o] = |hits;

      merge_on_a:
      assert property (@(posedge i_ref_clk) disable iff (i_rst)
         (i_core_cmd[0][o] && i_output_grant_map[0][o]) |=> o_drive_cmd[o])
         else $error("granted command not driven");
      ungranted_off_a:
      assert property (@(posedge i_ref_clk) disable iff (i_rst)
         ((i_core_cmd & i_output_grant_map) == '0) |=> o_drive_cmd == '0)
         else $error("ungranted command reached output");
   end

   assign bd_gr = i_output_grant_map[i_bd_core];
   // end-of-line trim is signed and the result saturates at both ends
   assign lvl_sum = $signed({2'b00, st_r.blevel}) + 10'(signed'(i_boost_eol_trim));

   always_comb
   begin
      st_nxt = st_r;
      // first flops only feed second flops
      st_nxt.start_s1 = i_start_inputs;
      st_nxt.start_s2 = st_r.start_s1;
      st_nxt.fbk_s1 = i_vds_fbk;
      st_nxt.fbk_s2 = st_r.fbk_s1;
      st_nxt.cur_s1 = i_cur_fbk;
      st_nxt.cur_s2 = st_r.cur_s1;
      st_nxt.uv_s1 = i_uv_vccp;
      st_nxt.uv_s2 = st_r.uv_s1;
      st_nxt.amp_s1 = i_amp_out;
      st_nxt.amp_s2 = st_r.amp_s1;
      st_nxt.bcmp_s1 = i_boost_cmp;
      st_nxt.bcmp_s2 = st_r.bcmp_s1;
      st_nxt.drive = merged;
      st_nxt.diag = st_r.drive ^ st_r.fbk_s2;

      // backdoor: boost level is deliberately absent here
      if (i_bd_wr)
      begin
         case (i_bd_addr)
            oa_pkg::OFF_HS_DRAIN: st_nxt.hs_drain = fld_merge(st_r.hs_drain, i_bd_wdata[14:0],
                                                              bd_gr[4:0]);
            oa_pkg::OFF_HS_SRC: st_nxt.hs_src = fld_merge(st_r.hs_src, i_bd_wdata[14:0],
                                                          bd_gr[4:0]);
            oa_pkg::OFF_LS_A: st_nxt.ls_a = fld_merge(st_r.ls_a, i_bd_wdata[14:0],
                                                      bd_gr[9:5]);
            oa_pkg::OFF_LS_B:
            begin
               if (bd_gr[10])
               begin
                  st_nxt.ls_b = i_bd_wdata[2:0];
               end
            end
            oa_pkg::OFF_GRANTS:
            begin
               if (!i_regs_locked)
               begin
                  st_nxt.grants = i_bd_wdata[3:0];
               end
            end
            oa_pkg::OFF_DEB:
            begin
               if (!i_regs_locked && st_r.grants[i_bd_core])
               begin
                  st_nxt.deb = i_bd_wdata[12:0];
               end
            end
            default:
            begin
            end
         endcase
      end

      // lowest numbered granted core wins a tie
      for (int c = oa_pkg::NUM_CORES - 1; c >= 0; c--)
      begin
         if (i_core_lvl_wr[c] && st_r.grants[c])
         begin
            st_nxt.blevel = i_core_lvl_data[c];
         end
      end

      // host writes last, so they win over any core in the same cycle
      if (i_spi_wr)
      begin
         case (i_spi_addr)
            oa_pkg::OFF_HS_DRAIN: st_nxt.hs_drain = i_spi_wdata[14:0];
            oa_pkg::OFF_HS_SRC: st_nxt.hs_src = i_spi_wdata[14:0];
            oa_pkg::OFF_LS_A: st_nxt.ls_a = i_spi_wdata[14:0];
            oa_pkg::OFF_LS_B: st_nxt.ls_b = i_spi_wdata[2:0];
            oa_pkg::OFF_LVL: st_nxt.blevel = i_spi_wdata[7:0];
            oa_pkg::OFF_GRANTS:
            begin
               if (!i_regs_locked)
               begin
                  st_nxt.grants = i_spi_wdata[3:0];
               end
            end
            oa_pkg::OFF_DEB:
            begin
               if (!i_regs_locked)
               begin
                  st_nxt.deb = i_spi_wdata[12:0];
               end
            end
            default:
            begin
            end
         endcase
      end

      if (lvl_sum < 0)
      begin
         st_nxt.lvl_eff = '0;
      end
      else if (lvl_sum > 10'sd255)
      begin
         st_nxt.lvl_eff = '1;
      end
      else
      begin
         st_nxt.lvl_eff = lvl_sum[7:0];
      end

      // bootstrap timer restarts whenever the supply drops again
      if (st_r.uv_s2)
      begin
         st_nxt.tmr = '0;
         st_nxt.bs_done = 1'b0;
      end
      else if (!st_r.bs_done)
      begin
         if (st_r.tmr == TMR_W'(BS_WAIT_CYC - 1))
         begin
            st_nxt.bs_done = 1'b1;
         end
         else
         begin
            st_nxt.tmr = st_r.tmr + TMR_W'(1);
         end
      end
      for (int j = 0; j < oa_pkg::NUM_HS; j++)
      begin
         if (i_bs_init[j])
         begin
            st_nxt.src_eff[j*oa_pkg::THR_W +: oa_pkg::THR_W] =
               st_r.bs_done ? oa_pkg::SRC_THR_HI : oa_pkg::SRC_THR_LO;
         end
         else
         begin
            st_nxt.src_eff[j*oa_pkg::THR_W +: oa_pkg::THR_W] =
               st_r.hs_src[j*oa_pkg::THR_W +: oa_pkg::THR_W];
         end
      end

      if (i_spi_rd)
      begin
         case (i_spi_addr)
            oa_pkg::OFF_HS_DRAIN: st_nxt.rdata = {1'b0, st_r.hs_drain};
            oa_pkg::OFF_HS_SRC: st_nxt.rdata = {1'b0, st_r.src_eff};
            oa_pkg::OFF_LS_A: st_nxt.rdata = {1'b0, st_r.ls_a};
            oa_pkg::OFF_LS_B: st_nxt.rdata = {13'h0000, st_r.ls_b};
            oa_pkg::OFF_LVL: st_nxt.rdata = {8'h00, st_r.blevel};
            oa_pkg::OFF_GRANTS: st_nxt.rdata = {12'h0000, st_r.grants};
            oa_pkg::OFF_DEB: st_nxt.rdata = {3'h0, st_r.deb};
            default: st_nxt.rdata = 16'h0000;
         endcase
      end

      // one-way search: the trim only rises, so a negative offset ends at zero
      case (st_r.oc_state)
         oa_pkg::OC_IDLE:
         begin
            if (|i_oc_req)
            begin
               st_nxt.oc_trim = '0;
               st_nxt.oc_cnt = '0;
               st_nxt.oc_busy = 1'b1;
               st_nxt.oc_state = oa_pkg::OC_WAIT;
            end
         end
         oa_pkg::OC_WAIT:
         begin
            // let the amplifier and its synchroniser settle
            if (st_r.oc_cnt == 3'(oa_pkg::OC_SETTLE_CYC - 1))
            begin
               st_nxt.oc_state = oa_pkg::OC_STEP;
            end
            else
            begin
               st_nxt.oc_cnt = st_r.oc_cnt + 3'h1;
            end
         end
         oa_pkg::OC_STEP:
         begin
            if (st_r.amp_s2 && st_r.oc_trim != '1)
            begin
               st_nxt.oc_trim = st_r.oc_trim + 4'h1;
               st_nxt.oc_cnt = '0;
               st_nxt.oc_state = oa_pkg::OC_WAIT;
            end
            else
            begin
               st_nxt.oc_busy = 1'b0;
               st_nxt.oc_state = oa_pkg::OC_IDLE;
            end
         end
         default: st_nxt.oc_state = oa_pkg::OC_IDLE;
      endcase

      if (i_rst)
      begin
         st_nxt = '0;
         st_nxt.hs_drain = oa_pkg::THR_RST;
         st_nxt.hs_src = oa_pkg::THR_RST;
         st_nxt.ls_a = oa_pkg::THR_RST;
         st_nxt.blevel = oa_pkg::LVL_RST;
         st_nxt.grants = oa_pkg::GRANT_RST;
         st_nxt.deb = oa_pkg::DEB_RST;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      st_r <= st_nxt;
   end

   assign deb_if.sample = st_r.bcmp_s2;
   assign deb_if.policy = st_r.deb[oa_pkg::DEB_POLICY_BIT];
   assign deb_if.setting = st_r.deb[oa_pkg::DEB_W-1:0];

   boost_debounce u_deb (
      .i_ref_clk (i_ref_clk),
      .i_rst (i_rst),
      .deb (deb_if.filt)
   );

   assign o_spi_rdata = st_r.rdata;
   assign o_core_start = st_r.start_s2;
   assign o_core_fbk = st_r.fbk_s2;
   assign o_core_cur = st_r.cur_s2;
   assign o_drive_cmd = st_r.drive;
   assign o_diag_mismatch = st_r.diag;
   assign o_high_side_drain_limit = st_r.hs_drain;
   assign o_high_side_source_limit = st_r.src_eff;
   assign o_low_side_drain_limit = {st_r.ls_b, st_r.ls_a};
   assign o_boost_level = st_r.lvl_eff;
   assign o_boost_ok = deb_if.filtered;
   assign o_oc_trim = st_r.oc_trim;
   assign o_oc_busy = st_r.oc_busy;

   broadcast_delay_a:
   assert property (@(posedge i_ref_clk) (!$past(i_rst) && !$past(i_rst, 2))
      |-> o_core_start == $past(i_start_inputs, 2) && o_core_cur == $past(i_cur_fbk, 2))
      else $error("inputs not broadcast after two cycles");
   diag_compare_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !$past(i_rst) |-> o_diag_mismatch == ($past(o_drive_cmd) ^ $past(o_core_fbk)))
      else $error("diagnosis mismatch wrong");
   oc_start_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (st_r.oc_state == oa_pkg::OC_IDLE && |i_oc_req)
      |=> o_oc_busy && o_oc_trim == '0 ##4 st_r.oc_state == oa_pkg::OC_STEP)
      else $error("offset trim did not start");
   lvl_core_write_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_core_lvl_wr == 4'h1 && st_r.grants[0] && !i_spi_wr)
      |=> st_r.blevel == $past(i_core_lvl_data[0]))
      else $error("granted core level write lost");
   lvl_output_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_boost_eol_trim == 5'h00 && !$past(i_rst)) |=> o_boost_level == $past(st_r.blevel))
      else $error("boost level not applied");
   lvl_denied_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_core_lvl_wr != '0 && (i_core_lvl_wr & st_r.grants) == '0 && !i_spi_wr)
      |=> $stable(st_r.blevel))
      else $error("ungranted core changed boost level");
   eol_trim_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_boost_eol_trim == 5'h01 && st_r.blevel < 8'hff)
      |=> o_boost_level == $past(st_r.blevel) + 8'h01)
      else $error("end-of-line trim not applied");
   thr_host_write_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_spi_wr && i_spi_addr == oa_pkg::OFF_HS_DRAIN)
      |=> o_high_side_drain_limit == $past(i_spi_wdata[14:0]))
      else $error("host threshold write lost");
   thr_core_deny_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_bd_wr && i_bd_addr == oa_pkg::OFF_HS_DRAIN && !bd_gr[0] && !i_spi_wr)
      |=> $stable(st_r.hs_drain[2:0]))
      else $error("ungranted core changed threshold");
   src_readback_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_spi_rd && i_spi_addr == oa_pkg::OFF_HS_SRC)
      |=> o_spi_rdata == {1'b0, $past(st_r.src_eff)})
      else $error("source readback not effective value");
   deb_core_deny_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_bd_wr && i_bd_addr == oa_pkg::OFF_DEB && !st_r.grants[i_bd_core] && !i_spi_wr)
      |=> $stable(st_r.deb))
      else $error("ungranted filter write taken");
   lvl_backdoor_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_bd_wr && i_bd_addr == oa_pkg::OFF_LVL && !i_spi_wr && i_core_lvl_wr == '0)
      |=> $stable(st_r.blevel))
      else $error("backdoor reached boost level");
   src_init_low_a:
   assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_bs_init[0] && !st_r.bs_done) |=> o_high_side_source_limit[2:0] == oa_pkg::SRC_THR_LO)
      else $error("init source threshold not low");

   oc_run_c:
   cover property (@(posedge i_ref_clk) disable iff (i_rst) $fell(o_oc_busy) && o_oc_trim != '0);
   bs_raise_c:
   cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(st_r.bs_done));
   core_lvl_c:
   cover property (@(posedge i_ref_clk) disable iff (i_rst) (i_core_lvl_wr & st_r.grants) != '0);
   merge_c:
   cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_drive_cmd[0]));
endmodule

// ### tb/core_model.sv
// sequencer core stand-in: random commands and grants while running
// assumes the bench seeds $urandom before i_run rises
`timescale 1ns/1ps
module core_model (
   // clock and control
   input wire logic i_ref_clk,
   input wire logic i_run,
   input wire logic [3:0][11:0] i_fixed_grant,
   // to the block
   output logic [3:0][11:0] o_cmd,
   output logic [3:0][11:0] o_grant
);
   initial
   begin
      o_cmd = '0;
      o_grant = '0;
   end
   // new set just after each edge; grants fixed by the bench when idle
   always @(posedge i_ref_clk)
   begin
      #1;
      for (int k = 0; k < 4; k++)
      begin
         o_cmd[k] = i_run ? 12'($urandom) : 12'h000;
         o_grant[k] = i_run ? 12'($urandom) : i_fixed_grant[k];
      end
   end
endmodule

// ### tb/output_arbiter_threshold_regs_tb.sv
// self-checking bench for the output arbiter and threshold registers
// assumes core_model stands in for the sequencer cores
`timescale 1ns/1ps
module output_arbiter_threshold_regs_tb;
   logic clk = 0, rst = 1, swr = 0, srd = 0, bwr = 0, lck = 0, amp = 0, bcmp = 0, uv = 1;
   logic run = 0, bok, busy;
   logic [9:0] sa = '0, ba = '0;
   logic [15:0] sd = '0, bd = '0, rdat, q;
   logic [1:0] bc = '0;
   logic [3:0] lwr = '0, oreq = '0, cur = '0, trim, ocur;
   logic [3:0][7:0] ldat = '0;
   logic [3:0][11:0] cmd, gnt, fgnt = '0;
   logic [5:0] st = '0, ost;
   logic [4:0] bsi = '0, eol = '0;
   logic [11:0] vds = '0, drv, ofbk, diag, pe = '0;
   logic [14:0] hsd, hss, e;
   logic [17:0] lsd;
   logic [7:0] lvl;
   int errors = 0, samples_checked = 0, ncyc = 0;
   logic [9:0] ad [8] = '{10'h018a, 10'h018b, 10'h018c, 10'h018d, 10'h019b, 10'h019c,
                          10'h019d, 10'h0190};
   logic [15:0] mk [8] = '{16'h7fff, 16'h7fff, 16'h7fff, 16'h0007, 16'h00ff, 16'h000f,
                           16'h1fff, 16'h0000};
   output_arbiter_threshold_regs #(.BS_WAIT_CYC(20)) output_arbiter_threshold_regs_inst (
      .i_ref_clk(clk), .i_rst(rst), .i_spi_wr(swr), .i_spi_rd(srd), .i_spi_addr(sa),
      .i_spi_wdata(sd), .o_spi_rdata(rdat), .i_bd_wr(bwr), .i_bd_core(bc), .i_bd_addr(ba),
      .i_bd_wdata(bd), .i_regs_locked(lck), .i_core_lvl_wr(lwr), .i_core_lvl_data(ldat),
      .i_core_cmd(cmd), .i_output_grant_map(gnt), .i_oc_req(oreq), .i_start_inputs(st),
      .i_vds_fbk(vds), .i_cur_fbk(cur), .i_uv_vccp(uv), .i_amp_out(amp),
      .i_boost_cmp(bcmp), .i_bs_init(bsi), .i_boost_eol_trim(eol), .o_core_start(ost),
      .o_core_fbk(ofbk), .o_core_cur(ocur), .o_drive_cmd(drv), .o_diag_mismatch(diag),
      .o_high_side_drain_limit(hsd), .o_high_side_source_limit(hss),
      .o_low_side_drain_limit(lsd), .o_boost_level(lvl), .o_boost_ok(bok),
      .o_oc_trim(trim), .o_oc_busy(busy));
   core_model core_model_inst (.i_ref_clk(clk), .i_run(run), .i_fixed_grant(fgnt),
      .o_cmd(cmd), .o_grant(gnt));
   always #12.5 clk = ~clk;
   function automatic logic [11:0] merge(logic [3:0][11:0] c, logic [3:0][11:0] g);
      merge = '0;
      for (int k = 0; k < 4; k++)
         merge = merge | (c[k] & g[k]);
   endfunction
   task chk(string n, logic [21:0] s, logic [21:0] x);
      samples_checked++;
      if (s !== x)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask
   task cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // host access: w=1 write, w=0 read; read data settled on return
   task bus(logic w, logic [9:0] a, logic [15:0] d);
      cyc(1);
      {swr, srd, sa, sd} = {w, !w, a, d};
      cyc(1);
      {swr, srd} = 2'b00;
      cyc(1);
   endtask
   task bdw(logic [1:0] c, logic [9:0] a, logic [15:0] d);
      cyc(1);
      {bwr, bc, ba, bd} = {1'b1, c, a, d};
      cyc(1);
      bwr = 0;
      cyc(1);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      ncyc++;
      if (ncyc == 20000)
      begin
         errors++;
         wrap_up;
      end
   end
   initial
   begin
      q = 16'($urandom(32'h39d4));
      cyc(16);
      rst = 0;
      cyc(3);
      for (int k = 0; k < 8; k++)
      begin
         bus(0, ad[k], 16'h0000);
         chk("reset", rdat, (k == 6) ? 16'h0001 : 16'h0000);
      end
      $display("test reset done");
      bsi = 5'h01;
      bus(1, 10'h018b, 16'h7fff);
      chk("src init", hss, 15'h7ff9);
      bus(0, 10'h018b, 16'h0000);
      chk("src read", rdat, 16'h7ff9);
      uv = 0;
      cyc(30);
      chk("src raised", hss, 15'h7ffa);
      bsi = 5'h00;
      cyc(2);
      chk("src free", hss, 15'h7fff);
      $display("test bootstrap done");
      for (int k = 0; k < 8; k++)
      begin
         q = 16'($urandom);
         bus(1, ad[k], q);
         bus(0, ad[k], 16'h0000);
         chk("rw", rdat, q & mk[k]);
      end
      $display("test registers done");
      {st, vds, cur} = 22'($urandom);
      cyc(4);
      chk("bcast", {ost, ofbk, ocur}, {st, vds, cur});
      run = 1;
      repeat (60)
      begin
         @(posedge clk);
         e = 15'(merge(cmd, gnt));
         #2 chk("merge", drv, e);
         chk("diag", diag, pe ^ vds);
         pe = e[11:0];
      end
      run = 0;
      $display("test merge done");
      for (int k = 0; k < 4; k++)
      begin
         q = 16'($urandom);
         fgnt = '0;
         fgnt[q[1:0]][9:5] = q[6:2];
         bus(1, 10'h018c, 16'h0000);
         bdw(q[1:0], 10'h018c, 16'h7fff);
         e = '0;
         for (int f = 0; f < 5; f++)
            e[3*f +: 3] = {3{q[2+f]}};
         chk("backdoor", lsd[14:0], e);
      end
      $display("test backdoor done");
      bus(1, 10'h019b, 16'h00a5);
      chk("level", lvl, 8'ha5);
      bus(1, 10'h019c, 16'h0000);
      lck = 1;
      bus(1, 10'h019c, 16'h0004);
      lck = 0;
      bus(0, 10'h019c, 16'h0000);
      chk("lock", rdat, 16'h0000);
      for (int k = 0; k < 2; k++)
      begin
         {lwr, ldat[2]} = {4'h4, 8'h3c};
         cyc(1);
         lwr = 0;
         cyc(2);
         chk("core level", lvl, k ? 8'h3c : 8'ha5);
         bus(1, 10'h019c, 16'h0004);
      end
      bdw(2'h2, 10'h019b, 16'h0011);
      chk("bd level", lvl, 8'h3c);
      eol = 5'($urandom);
      cyc(2);
      chk("eol trim", lvl, 8'(8'h3c + {{3{eol[4]}}, eol}));
      eol = 5'h01;
      bus(1, 10'h019b, 16'h00ff);
      chk("eol sat", lvl, 8'hff);
      eol = 5'h00;
      $display("test boost done");
      bus(1, 10'h019c, 16'h0000);
      bus(1, 10'h019d, 16'h0003);
      bdw(2'h0, 10'h019d, 16'h0005);
      bus(0, 10'h019d, 16'h0000);
      chk("filt grant", rdat, 16'h0003);
      bcmp = ~bok;
      cyc(5);
      chk("filt hold", bok, !bcmp);
      cyc(1);
      chk("filt flip", bok, bcmp);
      bus(1, 10'h019d, 16'h1003);
      bcmp = ~bok;
      cyc(3);
      bcmp = ~bcmp;
      cyc(1);
      bcmp = ~bcmp;
      cyc(3);
      chk("filt slow", bok, !bcmp);
      cyc(1);
      chk("filt down", bok, bcmp);
      $display("test filter done");
      amp = 1;
      oreq = 4'h2;
      cyc(1);
      oreq = 0;
      cyc(1);
      chk("oc busy", busy, 1'b1);
      for (int k = 0; k < 120 && busy !== 1'b0; k++)
         cyc(1);
      chk("oc trim", {busy, trim}, 5'h0f);
      $display("test offset done");
      wrap_up;
   end
endmodule
